// file: dcc_pkg.sv
// dcc_pkg: constants for the downconverter channel configuration block
// assumes byte-wide registers reached over a plain strobe port
package dcc_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] DCC_ADDR_TEST2 = 16'h0367;
  localparam logic [15:0] DCC_ADDR_CTRL = 16'h0370;
  localparam logic [15:0] DCC_ADDR_INSEL = 16'h0371;
  localparam logic [15:0] DCC_ADDR_STATUS = 16'h03f0;
  localparam logic [15:0] DCC_ADDR_TSEL = 16'h0550;

  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] DCC_CTRL_RST = 8'h00;
  localparam logic [7:0] DCC_INSEL_RST = 8'h05;
  localparam logic [7:0] DCC_TEST2_RST = 8'h00;
  localparam logic [7:0] DCC_TSEL_RST = 8'h00;
  localparam logic [7:0] DCC_CTRL_MASK = 8'hff;
  localparam logic [7:0] DCC_INSEL_MASK = 8'hf5;
  localparam logic [7:0] DCC_TEST2_MASK = 8'h05;
  localparam logic [7:0] DCC_TSEL_MASK = 8'h0f;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DCC_MIX_BIT = 7;
  localparam int DCC_GAIN_BIT = 6;
  localparam int DCC_IFM_LSB = 4;
  localparam int DCC_C2R_BIT = 3;
  localparam int DCC_DEC_LSB = 0;
  localparam int DCC_EXT_LSB = 4;
  localparam int DCC_QSEL_BIT = 2;
  localparam int DCC_ISEL_BIT = 0;
  localparam int DCC_TI_BIT = 0;
  localparam int DCC_TQ_BIT = 2;

  // ------------------------------------------------------------
  // codes, stage mask bits, levels
  // ------------------------------------------------------------
  localparam logic [2:0] DCC_DEC_EXT = 3'b111;
  localparam int DCC_ST_HB1 = 0;
  localparam int DCC_ST_HB2 = 1;
  localparam int DCC_ST_HB3 = 2;
  localparam int DCC_ST_HB4 = 3;
  localparam int DCC_ST_TB = 4;
  localparam int DCC_ST_FB = 5;
  localparam int DCC_NST = 6;
  localparam logic [15:0] DCC_TEST_LEVEL = 16'h1fff;

  typedef enum logic [1:0] {DCC_IF_VAR, DCC_IF_ZERO, DCC_IF_FS, DCC_IF_TEST} dcc_ifm_t;

endpackage : dcc_pkg

// file: dcc_smp_if.sv
// dcc_smp_if: sample word with valid and ready between block modules
// assumes source and sink share one clock
`timescale 1ns/10ps
interface dcc_smp_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : dcc_smp_if

// file: dcc_fifo.sv
// dcc_fifo: small first-in first-out buffer for output samples
// assumes one clock; write side on an interface, read side plain
`timescale 1ns/10ps
module dcc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  dcc_smp_if.snk wr,
  output logic [W-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic do_wr, do_rd;

  // ------------------------------------------------------------
  // pointers
  // ------------------------------------------------------------
  always_comb begin
    do_wr = wr.valid && wr.ready;
    do_rd = rd_valid && rd_ready;
    next_wp = do_wr ? ((wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp = do_rd ? ((rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
    next_cnt = cnt + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage has no reset: contents are unseen while empty
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wr.data;
    end
  end

  assign wr.ready = (cnt != (AW + 1)'(DEPTH));
  assign rd_valid = (cnt != '0);
  assign rd_data = mem[rp];
endmodule : dcc_fifo

// file: dcc_pacer.sv
// dcc_pacer: keeps one input sample of every rate samples
// assumes step is a one-cycle pulse per accepted input sample
`timescale 1ns/10ps
module dcc_pacer #(
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic step,
  input wire logic [CW-1:0] rate,
  output logic keep
);
  logic [CW-1:0] cnt, next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (step) begin
      next_cnt = (cnt >= rate - 1'b1) ? '0 : cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign keep = step && (cnt == '0);
endmodule : dcc_pacer

// file: dcc_top.sv
// dcc_top: configuration and sample path of downconverter_three,
// plus the output test selection of downconverter_two
// assumes samples arrive on clk with valid/ready; nco and filter
// coefficients live outside, this block steers and paces them
//
// Operation
// - a set in-phase test enable swaps downconverter_two in-phase samples for test block A pattern.
// - mixer select 0 gives a real mixer fed from one channel, 1 a complex mixer.
// - gain select 1 doubles the output, 0 leaves it at unity.
// - the if mode field decodes 00 variable, 01 zero, 10 sample rate, 11 test.
// - complex-to-real 0 keeps both outputs valid, 1 gives in-phase only after an extra mix.
// - primary codes 000 to 011 pick halfband chains at rates 4, 8, 16, 2, halved with complex-to-real.
// - primary codes 100 to 110 add the thirdband stage for rates 6, 12, 24, halved with complex-to-real.
// - primary code 111 hands the chain to the extended field in the next register.
// - extended code 0 cascades four halfbands and the thirdband for rate 48 or 24.
// - extended codes 2, 3, 4 pair the fifthband with one to three halfbands for 10, 20, 40 or half.
// - the extended field is ignored unless the primary field is 111.
`timescale 1ns/10ps
module dcc_top #(
  parameter int SW = 14,
  parameter int OW = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [SW-1:0] samp_a,
  input wire logic [SW-1:0] samp_b,
  input wire logic samp_valid,
  output logic samp_ready,
  output logic [OW-1:0] out_i,
  output logic [OW-1:0] out_q,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_q_used,
  output logic [dcc_pkg::DCC_NST-1:0] stage_en,
  output logic [5:0] decim_rate,
  output dcc_pkg::dcc_ifm_t if_mode,
  output logic [3:0] test_sel,
  input wire logic [OW-1:0] two_i_in,
  input wire logic [OW-1:0] two_q_in,
  input wire logic [OW-1:0] test_pat_a,
  input wire logic [OW-1:0] test_pat_b,
  output logic [OW-1:0] two_i_out,
  output logic [OW-1:0] two_q_out
);
  import dcc_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ctrl, insel, test2, tsel;
  logic [7:0] next_ctrl, next_insel, next_test2, next_tsel;
  logic [7:0] next_rdata;
  logic [7:0] status;

  always_comb begin
    next_ctrl = ctrl;
    next_insel = insel;
    next_test2 = test2;
    next_tsel = tsel;
    // masks keep reserved bits zero whatever software writes
    if (reg_wr) begin
      unique case (reg_addr)
        DCC_ADDR_CTRL: next_ctrl = reg_wdata & DCC_CTRL_MASK;
        DCC_ADDR_INSEL: next_insel = reg_wdata & DCC_INSEL_MASK;
        DCC_ADDR_TEST2: next_test2 = reg_wdata & DCC_TEST2_MASK;
        DCC_ADDR_TSEL: next_tsel = reg_wdata & DCC_TSEL_MASK;
        default: ;
      endcase
    end
    // read data is zero outside the cycle after a read strobe
    next_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        DCC_ADDR_CTRL: next_rdata = ctrl;
        DCC_ADDR_INSEL: next_rdata = insel;
        DCC_ADDR_TEST2: next_rdata = test2;
        DCC_ADDR_TSEL: next_rdata = tsel;
        DCC_ADDR_STATUS: next_rdata = status;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= DCC_CTRL_RST;
      insel <= DCC_INSEL_RST;
      test2 <= DCC_TEST2_RST;
      tsel <= DCC_TSEL_RST;
      reg_rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      insel <= next_insel;
      test2 <= next_test2;
      tsel <= next_tsel;
      reg_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  logic cplx_mix, gain2, c2r;
  logic [2:0] dec_code;
  logic [3:0] ext_code;
  logic [5:0] base_rate;
  logic [DCC_NST-1:0] stages;

  always_comb begin
    cplx_mix = ctrl[DCC_MIX_BIT];
    gain2 = ctrl[DCC_GAIN_BIT];
    c2r = ctrl[DCC_C2R_BIT];
    if_mode = dcc_ifm_t'(ctrl[DCC_IFM_LSB +: 2]);
    dec_code = ctrl[DCC_DEC_LSB +: 3];
    ext_code = insel[DCC_EXT_LSB +: 4];
    stages = '0;
    base_rate = 6'd2;
    if (dec_code != DCC_DEC_EXT) begin
      unique case (dec_code)
        3'b000: begin
          stages = 6'b000011;
          base_rate = 6'd4;
        end
        3'b001: begin
          stages = 6'b000111;
          base_rate = 6'd8;
        end
        3'b010: begin
          stages = 6'b001111;
          base_rate = 6'd16;
        end
        3'b011: begin
          stages = 6'b000001;
          base_rate = 6'd2;
        end
        3'b100: begin
          stages = 6'b010001;
          base_rate = 6'd6;
        end
        3'b101: begin
          stages = 6'b010011;
          base_rate = 6'd12;
        end
        default: begin
          stages = 6'b010111;
          base_rate = 6'd24;
        end
      endcase
    end else begin
      // unlisted extended codes fall back to the single halfband
      unique case (ext_code)
        4'h0: begin
          stages = 6'b011111;
          base_rate = 6'd48;
        end
        4'h2: begin
          stages = 6'b100001;
          base_rate = 6'd10;
        end
        4'h3: begin
          stages = 6'b100011;
          base_rate = 6'd20;
        end
        4'h4: begin
          stages = 6'b100111;
          base_rate = 6'd40;
        end
        default: begin
          stages = 6'b000001;
          base_rate = 6'd2;
        end
      endcase
    end
  end

  assign stage_en = stages;
  assign decim_rate = c2r ? (base_rate >> 1) : base_rate;
  assign out_q_used = !c2r;
  assign test_sel = tsel[3:0];

  // ------------------------------------------------------------
  // input routing and mixing
  // ------------------------------------------------------------
  logic [1:0] phase, next_phase;
  logic [SW-1:0] raw_i, raw_q;
  logic signed [OW-1:0] mix_i, mix_q, g_i, g_q, res_i;
  logic accept, keep;

  dcc_smp_if #(.W(2 * OW)) fifo_in ();

  always_comb begin
    raw_i = insel[DCC_ISEL_BIT] ? samp_b : samp_a;
    // real mixer takes both paths from the in-phase channel
    if (cplx_mix) begin
      raw_q = insel[DCC_QSEL_BIT] ? samp_b : samp_a;
    end else begin
      raw_q = raw_i;
    end
    mix_i = OW'(signed'(raw_i));
    mix_q = OW'(signed'(raw_q));
    unique case (if_mode)
      DCC_IF_VAR, DCC_IF_ZERO: ;
      DCC_IF_FS: begin
        if (phase[0]) begin
          mix_i = -mix_i;
          mix_q = -mix_q;
        end
      end
      DCC_IF_TEST: begin
        // fixed level makes the output path checkable without a live signal
        mix_i = OW'(DCC_TEST_LEVEL);
        mix_q = '0;
      end
    endcase
    // headroom of two bits means doubling never overflows
    g_i = gain2 ? (mix_i <<< 1) : mix_i;
    g_q = gain2 ? (mix_q <<< 1) : mix_q;
    // quarter-rate rotation folds the complex pair into a real stream
    unique case (phase)
      2'd0: res_i = g_i;
      2'd1: res_i = -g_q;
      2'd2: res_i = -g_i;
      default: res_i = g_q;
    endcase
    if (!c2r) begin
      res_i = g_i;
    end
  end

  assign samp_ready = fifo_in.ready;
  assign accept = samp_valid && samp_ready;
  assign next_phase = accept ? phase + 2'd1 : phase;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

  // count survives a rate change; an old count above the new rate wraps on the next step
  dcc_pacer #(.CW(6)) u_pacer (
    .clk(clk),
    .arst_n(arst_n),
    .step(accept),
    .rate(decim_rate),
    .keep(keep)
  );

  // quadrature word is zero while only the real output is produced
  assign fifo_in.valid = samp_valid && keep;
  assign fifo_in.data = {res_i, (c2r ? {OW{1'b0}} : g_q)};

  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  logic [2*OW-1:0] fifo_out;

  // four words ride out a short sink stall; a longer one stalls the input side
  dcc_fifo #(.W(2 * OW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .wr(fifo_in),
    .rd_data(fifo_out),
    .rd_valid(out_valid),
    .rd_ready(out_ready)
  );

  assign out_i = fifo_out[2*OW-1:OW];
  assign out_q = fifo_out[OW-1:0];
  // status is read-only: its offset has no write decode
  assign status = {!fifo_in.ready, out_valid, decim_rate};

  // ------------------------------------------------------------
  // downconverter_two test pattern selection
  // ------------------------------------------------------------
  // registered so a pattern swap never glitches downstream
  logic [OW-1:0] next_two_i, next_two_q;

  always_comb begin
    next_two_i = test2[DCC_TI_BIT] ? test_pat_a : two_i_in;
    next_two_q = test2[DCC_TQ_BIT] ? test_pat_b : two_q_in;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      two_i_out <= '0;
      two_q_out <= '0;
    end else begin
      two_i_out <= next_two_i;
      two_q_out <= next_two_q;
    end
  end
endmodule : dcc_top

// file: dcc_top_props.sv
// dcc_top_props: decode and timing checks on dcc_top ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
module dcc_top_props #(
  parameter int OW = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [OW-1:0] out_i,
  input wire logic [OW-1:0] out_q,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_q_used,
  input wire logic [dcc_pkg::DCC_NST-1:0] stage_en,
  input wire logic [5:0] decim_rate,
  input wire logic [OW-1:0] two_i_in,
  input wire logic [OW-1:0] test_pat_a,
  input wire logic [OW-1:0] two_i_out
);
  import dcc_pkg::*;
  // ----
  // rate implied by the stage mask
  // ----
  function automatic logic [5:0] exp_rate(input logic [5:0] s, input logic q);
    int r;
    r = 1;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) r = r * 2;
    end
    if (s[DCC_ST_TB]) r = r * 3;
    if (s[DCC_ST_FB]) r = r * 5;
    if (!q) r = r / 2;
    return r[5:0];
  endfunction : exp_rate
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_hb1; stage_en[DCC_ST_HB1]; endproperty
  a_hb1: assert property (p_hb1) else $error("halfband one off");
  property p_chain; stage_en[3:0] inside {4'h1, 4'h3, 4'h7, 4'hf}; endproperty
  a_chain: assert property (p_chain) else $error("halfband chain gap");
  property p_excl; !(stage_en[DCC_ST_TB] && stage_en[DCC_ST_FB]); endproperty
  a_excl: assert property (p_excl) else $error("third and fifth band both on");
  property p_rate; decim_rate == exp_rate(stage_en, out_q_used); endproperty
  a_rate: assert property (p_rate) else $error("rate does not match stages");
  property p_qzero; out_valid && !out_q_used |-> out_q == '0; endproperty
  a_qzero: assert property (p_qzero) else $error("quadrature not zero in real output");
  property p_two_i;
    $past(arst_n) |-> two_i_out == $past(two_i_in) || two_i_out == $past(test_pat_a);
  endproperty
  a_two_i: assert property (p_two_i) else $error("in-phase output neither sample nor pattern");
  property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its cycle");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q); endproperty
  a_hold: assert property (p_hold) else $error("output head changed while stalled");
endmodule : dcc_top_props
bind dcc_top dcc_top_props #(.OW(OW)) i_props (.clk(clk), .arst_n(arst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .out_i(out_i), .out_q(out_q), .out_valid(out_valid), .out_ready(out_ready),
  .out_q_used(out_q_used), .stage_en(stage_en), .decim_rate(decim_rate), .two_i_in(two_i_in),
  .test_pat_a(test_pat_a), .two_i_out(two_i_out));

// file: dcc_src_model.sv
// dcc_src_model: two converter sample channels feeding the block
// assumes valid/ready taken on the rising clock edge
`timescale 1ns/10ps
module dcc_src_model #(
  parameter int SW = 14
) (
  input wire logic clk,
  input wire logic src_on,
  input wire logic [SW-1:0] a_val,
  input wire logic [SW-1:0] b_val,
  input wire logic samp_ready,
  output logic [SW-1:0] samp_a,
  output logic [SW-1:0] samp_b,
  output logic samp_valid
);
  initial begin
    samp_valid = 1'b0;
    samp_a = '0;
    samp_b = '0;
  end
  always @(posedge clk) begin
    if (samp_valid && !samp_ready) begin
      samp_valid <= 1'b1;
    end else if (src_on) begin
      samp_valid <= 1'b1;
      samp_a <= a_val;
      samp_b <= b_val;
    end else begin
      // no stale word left on idle lines
      samp_valid <= 1'b0;
      samp_a <= ~samp_a;
      samp_b <= ~samp_b;
    end
  end
endmodule : dcc_src_model

// file: test_downconverter_channel_config.sv
// test_downconverter_channel_config: self-checking bench for dcc_top
// assumes dcc_src_model as sample source, 10 MHz clock
`timescale 1ns/10ps
module test_downconverter_channel_config;
  import dcc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, out_ready = 1'b0, src_on = 1'b0;
  logic [15:0] reg_addr = 16'h0000, two_i_in = 16'h0000, test_pat_a = 16'h0000;
  logic [15:0] two_q_in = 16'h0000, test_pat_b = 16'h0000, two_q_out;
  logic [13:0] a_val = 14'h0123, b_val = 14'h0456;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [13:0] samp_a, samp_b;
  logic samp_valid, samp_ready, out_valid, out_q_used;
  logic [15:0] out_i, out_q, two_i_out, v0, q0, vi, vq;
  logic [5:0] stage_en, decim_rate;
  logic [3:0] test_sel;
  dcc_ifm_t if_mode;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [5:0] rate_t [0:6] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0c, 6'h18};
  logic [5:0] stg_t [0:6] = '{6'h03, 6'h07, 6'h0f, 6'h01, 6'h11, 6'h13, 6'h17};
  logic [5:0] xrate_t [0:2] = '{6'h0a, 6'h14, 6'h28};
  logic [5:0] xstg_t [0:2] = '{6'h21, 6'h23, 6'h27};
  always #50 clk = ~clk;
  dcc_top #(.SW(14), .OW(16), .FIFO_DEPTH(4)) i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_a(samp_a),
    .samp_b(samp_b), .samp_valid(samp_valid), .samp_ready(samp_ready), .out_i(out_i), .out_q(out_q),
    .out_valid(out_valid), .out_ready(out_ready), .out_q_used(out_q_used), .stage_en(stage_en),
    .decim_rate(decim_rate), .if_mode(if_mode), .test_sel(test_sel), .two_i_in(two_i_in),
    .two_q_in(two_q_in), .test_pat_a(test_pat_a), .test_pat_b(test_pat_b), .two_i_out(two_i_out),
    .two_q_out(two_q_out));
  dcc_src_model #(.SW(14)) i_src (.clk(clk), .src_on(src_on), .a_val(a_val), .b_val(b_val),
    .samp_ready(samp_ready), .samp_a(samp_a), .samp_b(samp_b), .samp_valid(samp_valid));
  // ----
  // shared tasks
  // ----
  task close_out;
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(16'(reg_rdata), 16'(exp));
  endtask : rd
  task cfg_chk(input logic [7:0] c, input logic [5:0] r, input logic [5:0] s);
    wr(DCC_ADDR_CTRL, c);
    @(negedge clk);
    chk(16'(decim_rate), 16'(r));
    chk(16'(stage_en), 16'(s));
  endtask : cfg_chk
  // fill until refused, then drain until empty; same asks every in-phase word equal to the first
  task stream(input logic [7:0] c, input logic same, output logic [15:0] si, output logic [15:0] sq);
    int n;
    int cnt;
    int idle;
    wr(DCC_ADDR_CTRL, c);
    @(posedge clk);
    src_on <= 1'b1;
    n = 0;
    while (samp_ready !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(16'(out_valid), 16'h0001);
    @(posedge clk);
    src_on <= 1'b0;
    out_ready <= 1'b1;
    cnt = 0;
    idle = 0;
    while (idle < 4 && n < 200) begin
      @(negedge clk);
      n++;
      idle++;
      if (out_valid === 1'b1) begin
        if (cnt == 0) begin
          si = out_i;
          sq = out_q;
        end else if (same) begin
          chk(out_i, si);
        end
        cnt++;
        idle = 0;
      end
    end
    @(posedge clk);
    out_ready <= 1'b0;
    chk(16'(cnt >= 4), 16'h0001);
  endtask : stream
  // ----
  // scenarios
  // ----
  task t_regs;
    rd(DCC_ADDR_CTRL, DCC_CTRL_RST);
    rd(DCC_ADDR_INSEL, DCC_INSEL_RST);
    rd(16'h0372, 8'h00);
    rd(DCC_ADDR_STATUS, 8'h04);
    wr(DCC_ADDR_INSEL, 8'hff);
    rd(DCC_ADDR_INSEL, 8'hf5);
    wr(DCC_ADDR_TEST2, 8'hff);
    rd(DCC_ADDR_TEST2, 8'h05);
    wr(DCC_ADDR_TSEL, 8'hfa);
    rd(DCC_ADDR_TSEL, 8'h0a);
    chk(16'(test_sel), 16'h000a);
    $display("registers done");
  endtask : t_regs
  task t_decode;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 7; k++) begin
        cfg_chk({4'h0, f[0], k[2:0]}, rate_t[k] >> f, stg_t[k]);
        chk(16'(out_q_used), 16'(!f[0]));
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr(DCC_ADDR_CTRL, {2'h0, m[1:0], 4'h0});
      @(negedge clk);
      chk(16'(if_mode), 16'(m));
    end
    wr(DCC_ADDR_INSEL, 8'h05);
    cfg_chk(8'h07, 6'h30, 6'h1f);
    cfg_chk(8'h0f, 6'h18, 6'h1f);
    for (int e = 0; e < 3; e++) begin
      wr(DCC_ADDR_INSEL, {4'(e + 2), 4'h5});
      cfg_chk(8'h07, xrate_t[e], xstg_t[e]);
    end
    cfg_chk(8'h0f, 6'h14, 6'h27);
    cfg_chk(8'h00, 6'h04, 6'h03);
    $display("decode done");
  endtask : t_decode
  task t_two;
    wr(DCC_ADDR_TEST2, 8'h01);
    two_i_in <= 16'h1111;
    two_q_in <= 16'h3333;
    test_pat_a <= 16'h2222;
    test_pat_b <= 16'h4444;
    @(posedge clk);
    @(negedge clk);
    chk(two_i_out, 16'h2222);
    chk(two_q_out, 16'h3333);
    wr(DCC_ADDR_TEST2, 8'h04);
    @(posedge clk);
    @(negedge clk);
    chk(two_i_out, 16'h1111);
    chk(two_q_out, 16'h4444);
    $display("test path done");
  endtask : t_two
  task t_stream;
    wr(DCC_ADDR_INSEL, 8'h01);
    stream(8'h03, 1'b1, v0, q0);
    chk(q0, v0);
    chk(v0, 16'(b_val));
    stream(8'h43, 1'b1, vi, vq);
    chk(vi, v0 << 1);
    stream(8'h83, 1'b1, vi, vq);
    chk(16'(vq === vi), 16'h0000);
    chk(vi, 16'(b_val));
    chk(vq, 16'(a_val));
    stream(8'h33, 1'b1, vi, vq);
    chk(vi, DCC_TEST_LEVEL);
    chk(vq, 16'h0000);
    stream(8'h08, 1'b0, vi, vq);
    chk(vq, 16'h0000);
    chk(16'(vi == 16'(b_val) || vi == -16'(b_val)), 16'h0001);
    $display("stream done");
  endtask : t_stream
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_decode();
    t_two();
    t_stream();
    close_out();
  end
endmodule : test_downconverter_channel_config
